//--- core/adl_pkg.sv
// Purpose: Shared constants and types for the front-end data and control link.
// Assumes: One 25 MHz core clock; the front-end reference clock is sampled as a pin.
// Notes: The serial frame is read/write bit, seven address bits, eight data bits.

package adl_pkg;

    // ----------------------------------------------------------------
    // Widths of the sample buses and the control frame
    // ----------------------------------------------------------------
    localparam int TX_WIDTH = 4;
    localparam int RX_WIDTH = 6;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 16;

    // ----------------------------------------------------------------
    // Field positions inside the sixteen-bit frame and the access word
    // ----------------------------------------------------------------
    localparam int RW_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int ACCESS_RW_POS = 7;
    localparam int DATA_FIELD_FIRST = 8;

    // ----------------------------------------------------------------
    // Counts and values after reset
    // ----------------------------------------------------------------
    localparam logic [4:0] LAST_BIT = 5'h0F;
    localparam logic [4:0] COUNT_RST = 5'h00;
    localparam logic [15:0] FRAME_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] TX_RST = 4'h0;
    localparam logic [5:0] RX_RST = 6'h00;

    // ----------------------------------------------------------------
    // Serial control sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_FALL,
        ST_SHIFT,
        ST_FINISH
    } adl_state_e;

endpackage : adl_pkg

//--- core/adl_link.sv
// Purpose: Transceiver side of the link to the analog front end: sample buses and serial control.
// Assumes: FRONTEND_REF_CLOCK is far slower than CLOCK and is found by sampling it.
// Notes: Outputs toward the front end change after a falling reference edge so they are stable at the rising one.
//
// What this block does
// - Send the four-bit oversampled transmit stream on the parallel transmit sample bus.
// - Each transmit word is transferred on a rising reference clock edge.
// - A control transaction starts with select driven low; idle while select high.
// - The access register value sets read or write and the addressed register.
// - The read/write bit goes out on the serial output line.
// - Each transaction carries exactly sixteen bits, one per rising reference edge.
// - Write data leaves on serial output; read data returns on serial input.
// - Seven address bits then eight data bits, each most significant bit first.

`timescale 1ns/100ps
`default_nettype none

module adl_link (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic FRONTEND_REF_CLOCK,
    input wire logic [3:0] TX_SAMPLE_IN,
    output logic TX_SAMPLE_TAKE,
    output logic [3:0] TX_SAMPLE_OUT,
    input wire logic [5:0] RX_SAMPLE_PIN,
    output logic [5:0] RX_SAMPLE_OUT,
    output logic RX_SAMPLE_STROBE,
    input wire logic ACCESS_WRITE,
    input wire logic [7:0] FRONTEND_ACCESS_REG,
    input wire logic [7:0] FRONTEND_CONFIG_REG,
    input wire logic STATUS_CLEAR,
    output logic STATUS_BUSY,
    output logic STATUS_DONE,
    output logic [7:0] STATUS_READ_DATA,
    output logic FRONTEND_SELECT_N,
    output logic CTL_SERIAL_OUT,
    input wire logic CTL_SERIAL_IN
);

    // ----------------------------------------------------------------
    // Pin synchronisers and reference edge detection
    // ----------------------------------------------------------------
    logic ref_meta, ref_sync, ref_prev;
    logic sin_meta, sin_sync;
    logic [5:0] rx_meta, rx_sync;
    logic ref_rise, ref_fall;

    // Two flops on every pin, plus a third on the reference for edge detection; the first flop never feeds logic.
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ref_meta <= 1'b0;
            ref_sync <= 1'b0;
            ref_prev <= 1'b0;
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
            rx_meta <= adl_pkg::RX_RST;
            rx_sync <= adl_pkg::RX_RST;
        end else begin
            ref_meta <= FRONTEND_REF_CLOCK;
            ref_sync <= ref_meta;
            ref_prev <= ref_sync;
            sin_meta <= CTL_SERIAL_IN;
            sin_sync <= sin_meta;
            rx_meta <= RX_SAMPLE_PIN;
            rx_sync <= rx_meta;
        end
    end

    // Edges of the reference clock as seen in the core domain.
    assign ref_rise = ref_sync & ~ref_prev;
    assign ref_fall = ~ref_sync & ref_prev;

    // ----------------------------------------------------------------
    // Sample buses
    // ----------------------------------------------------------------
    logic [3:0] next_tx_out;
    logic [5:0] next_rx_out;
    logic next_rx_strobe;

    // Transmit word changes after a fall so the front end takes it on the rise; receive word taken on the rise.
    always_comb begin
        next_tx_out = ref_fall ? TX_SAMPLE_IN : TX_SAMPLE_OUT;
        next_rx_out = ref_rise ? rx_sync : RX_SAMPLE_OUT;
        next_rx_strobe = ref_rise;
    end

    // Registers for the sample buses.
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            TX_SAMPLE_OUT <= adl_pkg::TX_RST;
            RX_SAMPLE_OUT <= adl_pkg::RX_RST;
            RX_SAMPLE_STROBE <= 1'b0;
        end else begin
            TX_SAMPLE_OUT <= next_tx_out;
            RX_SAMPLE_OUT <= next_rx_out;
            RX_SAMPLE_STROBE <= next_rx_strobe;
        end
    end

    // The modulator advances its stream when a word is taken.
    assign TX_SAMPLE_TAKE = ref_fall;

    // ----------------------------------------------------------------
    // Serial control sequencer
    // ----------------------------------------------------------------
    adl_pkg::adl_state_e state, next_state;
    logic [15:0] frame, next_frame;
    logic [4:0] count, next_count;
    logic [7:0] rd_shift, next_rd_shift;
    logic [7:0] next_read_data;
    logic next_select_n, next_serial_out, next_done;
    logic accept;

    // A new access is taken only while idle; a write during a transfer is ignored.
    assign accept = ACCESS_WRITE && (state == adl_pkg::ST_IDLE);

    // Next values of the sequencer, the pins and the status.
    always_comb begin
        next_state = state;
        next_frame = frame;
        next_count = count;
        next_rd_shift = rd_shift;
        next_read_data = STATUS_READ_DATA;
        next_select_n = FRONTEND_SELECT_N;
        next_serial_out = CTL_SERIAL_OUT;
        next_done = STATUS_DONE & ~STATUS_CLEAR;
        unique case (state)
            adl_pkg::ST_IDLE: begin
                next_select_n = 1'b1;
                if (accept) begin
                    // Read/write bit first, then address, then data, most significant first.
                    next_frame = {FRONTEND_ACCESS_REG, FRONTEND_CONFIG_REG};
                    next_count = adl_pkg::COUNT_RST;
                    next_state = adl_pkg::ST_WAIT_FALL;
                end
            end
            adl_pkg::ST_WAIT_FALL: begin
                if (ref_fall) begin
                    next_select_n = 1'b0;
                    next_serial_out = frame[adl_pkg::RW_POS];
                    next_state = adl_pkg::ST_SHIFT;
                end
            end
            adl_pkg::ST_SHIFT: begin
                if (ref_rise) begin
                    if (count >= 5'(adl_pkg::DATA_FIELD_FIRST)) begin
                        next_rd_shift = {rd_shift[6:0], sin_sync};
                    end
                    if (count == adl_pkg::LAST_BIT) begin
                        next_state = adl_pkg::ST_FINISH;
                    end else begin
                        next_count = count + 5'h01;
                    end
                end else if (ref_fall) begin
                    next_serial_out = frame[4'(adl_pkg::RW_POS) - count[3:0]];
                end
            end
            adl_pkg::ST_FINISH: begin
                if (ref_fall) begin
                    next_select_n = 1'b1;
                    next_serial_out = 1'b0;
                    next_read_data = rd_shift;
                    next_done = 1'b1;
                    next_state = adl_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            state <= adl_pkg::ST_IDLE;
            frame <= adl_pkg::FRAME_RST;
            count <= adl_pkg::COUNT_RST;
            rd_shift <= adl_pkg::BYTE_RST;
            STATUS_READ_DATA <= adl_pkg::BYTE_RST;
            FRONTEND_SELECT_N <= 1'b1;
            CTL_SERIAL_OUT <= 1'b0;
            STATUS_DONE <= 1'b0;
        end else begin
            state <= next_state;
            frame <= next_frame;
            count <= next_count;
            rd_shift <= next_rd_shift;
            STATUS_READ_DATA <= next_read_data;
            FRONTEND_SELECT_N <= next_select_n;
            CTL_SERIAL_OUT <= next_serial_out;
            STATUS_DONE <= next_done;
        end
    end

    // Busy from the moment an access is taken until select returns high.
    assign STATUS_BUSY = (state != adl_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [4:0] chk_rises;

    // Counts reference rises seen while select is low.
    always_ff @(posedge CLOCK) begin
        if (!RST_B || FRONTEND_SELECT_N) begin
            chk_rises <= adl_pkg::COUNT_RST;
        end else if (ref_rise) begin
            chk_rises <= chk_rises + 5'h01;
        end
    end

    default clocking chk_clk @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    chk_select_idle: assert property (state == adl_pkg::ST_IDLE |-> FRONTEND_SELECT_N)
        else $error("Select low while the sequencer is idle.");
    chk_start_low: assert property (accept |-> ##[1:12] !FRONTEND_SELECT_N)
        else $error("Select not driven low after an access was taken.");
    chk_rw_first_bit: assert property ($fell(FRONTEND_SELECT_N) |-> CTL_SERIAL_OUT == frame[15])
        else $error("First serial bit is not the read/write bit.");
    chk_sixteen_bits: assert property ($rose(FRONTEND_SELECT_N) |-> $past(chk_rises) == 5'h10)
        else $error("Frame did not carry sixteen bits.");
    chk_tx_after_fall: assert property ($changed(TX_SAMPLE_OUT) |-> $past(ref_fall))
        else $error("Transmit word changed away from a falling reference edge.");
    chk_rx_on_rise: assert property (RX_SAMPLE_STROBE |-> $past(ref_rise) && RX_SAMPLE_OUT == $past(rx_sync))
        else $error("Receive word not taken on a rising reference edge.");
    chk_serial_stable: assert property (ref_rise && !FRONTEND_SELECT_N |=> $stable(CTL_SERIAL_OUT))
        else $error("Serial output moved at a rising reference edge.");
    chk_done_flag: assert property ($rose(FRONTEND_SELECT_N) |-> STATUS_DONE && !STATUS_BUSY)
        else $error("Completion not shown when select returned high.");
    chk_done_set_wins: assert property (state == adl_pkg::ST_FINISH && ref_fall |=> STATUS_DONE)
        else $error("Completion flag lost to a simultaneous clear.");
    chk_access_fields: assert property (accept |=> frame == $past({FRONTEND_ACCESS_REG, FRONTEND_CONFIG_REG}))
        else $error("Frame does not match the access and config values.");
    chk_busy_refuse: assert property (ACCESS_WRITE && STATUS_BUSY |=> $stable(frame))
        else $error("Access accepted during a transfer.");

    cov_write_frame: cover property (accept && !FRONTEND_ACCESS_REG[7] ##[1:200] $rose(FRONTEND_SELECT_N));
    cov_read_frame: cover property (accept && FRONTEND_ACCESS_REG[7] ##[1:200] $rose(FRONTEND_SELECT_N));
    cov_refused: cover property (ACCESS_WRITE && STATUS_BUSY);
    cov_clear_race: cover property (STATUS_CLEAR && $rose(FRONTEND_SELECT_N));

endmodule : adl_link

`default_nettype wire

//--- verif/adl_fe_model.sv
// Purpose: Behavioural front end: reference clock, serial slave and receive sample source.
// Assumes: The reference clock runs free with a 320 ns period.
// Notes: A released serial input toggles, so stale data never looks valid.

`timescale 1ns/100ps
`default_nettype none

module adl_fe_model (
    output logic ref_clk,
    input wire logic select_n,
    input wire logic serial_out,
    output logic serial_in,
    output logic [5:0] rx_pin,
    output logic [15:0] frame_word,
    output logic [4:0] frame_bits,
    output logic frame_stb
);
    logic [7:0] regs [0:127];
    logic [15:0] shift;
    logic [7:0] rd_byte;
    logic [4:0] cnt;
    logic rd_mode;

    // Halved crystal clock, offset from the core clock edges.
    initial begin
        ref_clk = 1'b0;
        serial_in = 1'b0;
        rx_pin = 6'h00;
        frame_stb = 1'b0;
        cnt = 5'h00;
        rd_mode = 1'b0;
        for (int i = 0; i < 128; i++) regs[i] = 8'h00;
        #13;
        forever #160 ref_clk = ~ref_clk;
    end

    // One frame bit is taken on each rising edge while selected.
    always @(posedge ref_clk) begin
        if (select_n === 1'b0) begin
            shift <= {shift[14:0], serial_out};
            cnt <= cnt + 5'h01;
        end
    end

    // Receive samples and read data change after each falling edge.
    always @(negedge ref_clk) begin
        rx_pin <= 6'($urandom);
        if (select_n === 1'b0 && cnt == 5'h08 && shift[7] === 1'b1) begin
            serial_in <= regs[shift[6:0]][7];
            rd_byte <= {regs[shift[6:0]][6:0], 1'b0};
            rd_mode <= 1'b1;
        end else if (select_n === 1'b0 && cnt > 5'h08 && rd_mode) begin
            serial_in <= rd_byte[7];
            rd_byte <= {rd_byte[6:0], 1'b0};
        end else begin
            serial_in <= ~serial_in;
        end
    end

    // The frame ends when select returns high; writes land in the register file.
    always @(posedge select_n) begin
        frame_word = shift;
        frame_bits = cnt;
        if (shift[15] === 1'b0) regs[shift[14:8]] = shift[7:0];
        cnt = 5'h00;
        rd_mode = 1'b0;
        frame_stb = 1'b1;
        #40 frame_stb = 1'b0;
    end
endmodule : adl_fe_model

`default_nettype wire

//--- verif/test_adl_link.sv
// Purpose: Self-checking bench for the front-end data and control link.
// Assumes: Core clock 25 MHz, reference clock 320 ns from the partner model.
// Notes: Expected values are queued by the drivers and checked by watchers.

`timescale 1ns/100ps
`default_nettype none

module test_adl_link;
    logic clock, rst_b, ref_clk, tx_take, rx_stb, acc_wr, st_clr, busy, done, sel_n, sdo, sdi, frame_stb;
    logic ready, done_prev;
    logic [3:0] tx_in, tx_out;
    logic [5:0] rx_pin, rx_out;
    logic [7:0] acc_reg, cfg_reg, rd_data;
    logic [7:0] shadow [0:127];
    logic [6:0] addrs [0:3];
    logic [15:0] frame_word;
    logic [4:0] frame_bits;
    logic [8:0] exp9;
    logic [15:0] frame_q [$];
    logic [8:0] rd_q [$];
    logic [3:0] tx_q [$];
    logic [5:0] rx_q [$];
    int error_cnt, checks;

    adl_link i_adl_link (.CLOCK(clock), .RST_B(rst_b), .FRONTEND_REF_CLOCK(ref_clk), .TX_SAMPLE_IN(tx_in),
        .TX_SAMPLE_TAKE(tx_take), .TX_SAMPLE_OUT(tx_out), .RX_SAMPLE_PIN(rx_pin), .RX_SAMPLE_OUT(rx_out),
        .RX_SAMPLE_STROBE(rx_stb), .ACCESS_WRITE(acc_wr), .FRONTEND_ACCESS_REG(acc_reg),
        .FRONTEND_CONFIG_REG(cfg_reg), .STATUS_CLEAR(st_clr), .STATUS_BUSY(busy), .STATUS_DONE(done),
        .STATUS_READ_DATA(rd_data), .FRONTEND_SELECT_N(sel_n), .CTL_SERIAL_OUT(sdo), .CTL_SERIAL_IN(sdi));
    adl_fe_model i_adl_fe_model (.ref_clk(ref_clk), .select_n(sel_n), .serial_out(sdo), .serial_in(sdi),
        .rx_pin(rx_pin), .frame_word(frame_word), .frame_bits(frame_bits), .frame_stb(frame_stb));

    // Core clock.
    always #20 clock = ~clock;

    // Compares a frame or a count.
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    // Compares a byte or a sample word.
    task automatic chk_small(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_small

    // Waits for idle, then issues one access; poke tries a refused access before select falls.
    task automatic access(input logic rd, input logic [6:0] addr, input logic [7:0] data, input logic poke);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            $display("ERROR idle wait expected 0 seen %b", busy);
        end
        acc_wr = 1'b1;
        acc_reg = {rd, addr};
        cfg_reg = data;
        st_clr = 1'b1;
        frame_q.push_back({rd, addr, data});
        rd_q.push_back({rd, rd ? shadow[addr] : 8'h00});
        if (!rd) shadow[addr] = data;
        @(posedge clock);
        #1;
        acc_wr = 1'b0;
        st_clr = 1'b0;
        chk_small("busy", 8'h01, {7'h00, busy});
        chk_small("done cleared", 8'h00, {7'h00, done});
        if (poke) begin
            repeat (5) @(posedge clock);
            #1;
            acc_wr = 1'b1;
            acc_reg = ~acc_reg;
            @(posedge clock);
            #1;
            acc_wr = 1'b0;
        end
    endtask : access

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    // Completion and sample watcher: read byte arrives with the rise of done; receive words are checked and transmit words queued.
    always @(posedge clock) begin
        done_prev <= done;
        if (done === 1'b1 && done_prev === 1'b0 && rd_q.size() > 0) begin
            exp9 = rd_q.pop_front();
            if (exp9[8]) chk_small("read byte", exp9[7:0], rd_data);
        end
        if (rx_stb === 1'b1 && rx_q.size() > 0) chk_small("rx word", {2'h0, rx_q.pop_front()}, {2'h0, rx_out});
        if (tx_take === 1'b1 && ready) begin
            tx_q.push_back(tx_in);
            #1 tx_in = 4'($urandom);
        end
    end

    // Frame watcher at the far side.
    always @(posedge frame_stb) begin
        if (frame_q.size() > 0) begin
            chk_word("frame", frame_q.pop_front(), frame_word);
            chk_word("bit count", 16'h0010, {11'h000, frame_bits});
        end
    end

    // Sample buses as the front end sees them on its rising edge.
    always @(posedge ref_clk) begin
        if (tx_q.size() > 0) chk_small("tx word", {4'h0, tx_q.pop_front()}, {4'h0, tx_out});
        if (ready) rx_q.push_back(rx_pin);
    end

    // Watchdog.
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("ERROR watchdog expected finish seen timeout");
        summarize();
    end

    // Main sequence.
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        tx_in = 4'h0;
        acc_wr = 1'b0;
        acc_reg = 8'h00;
        cfg_reg = 8'h00;
        st_clr = 1'b0;
        ready = 1'b0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'h9B97));
        addrs = '{7'h00, 7'h7F, 7'($urandom), 7'($urandom)};
        repeat (6) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge clock);
        #1 ready = 1'b1;
        for (int i = 0; i < 4; i++) access(1'b0, addrs[i], 8'($urandom), i == 2);
        $display("test writes done");
        for (int i = 0; i < 4; i++) access(1'b1, addrs[i], 8'($urandom), i == 1);
        $display("test reads done");
        access(1'b0, addrs[3], 8'h00, 1'b0);
        // Clear is held over the last completion, so the set of the flag must win.
        @(posedge clock);
        #1 st_clr = 1'b1;
        repeat (400) @(posedge clock);
        #1 st_clr = 1'b0;
        // Every access must have completed and been seen at both sides.
        chk_word("pending results", 16'h0000, 16'(rd_q.size() + frame_q.size()));
        $display("test streams done");
        summarize();
    end
endmodule : test_adl_link

`default_nettype wire
